// >>> etc_core_model.sv
// Core-side model issuing register writes and reads
`timescale 1ns/100ps
module etc_core_model (
	input  wire        clk_sys,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic       reg_wr = 1'b0,
	output logic       reg_rd = 1'b0,
	input  wire  [7:0] reg_rdata
);
	task wr(input logic [7:0] a, input logic [7:0] d);
	begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(posedge clk_sys);
	end
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
	begin
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		d = reg_rdata;
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	end
	endtask
endmodule // etc_core_model

// >>> etc_map.vh
// Constants and register layout for the eight-bit timer control block
`ifndef ETC_MAP_VH
`define ETC_MAP_VH
`define ETC_ADDR_BANK_PTR   8'hfd
`define ETC_BANK_NORMAL     4'h0
`define ETC_BANK_TIMER      4'hd
`define ETC_BANK_STOP       4'hf
`define ETC_LOC_T8CTL       4'h0
`define ETC_LOC_SHARED      4'h1
`define ETC_LOC_T16CTL      4'h2
`define ETC_BIT_EN          7
`define ETC_BIT_ONESHOT     6
`define ETC_BIT_TC          5
`define ETC_BIT_CAPMASK     2
`define ETC_BIT_TOMASK      1
`define ETC_BIT_PINA        0
`define ETC_BIT_MODE        7
`define ETC_BIT_PINB        6
`define ETC_BIT_CAPHI       1
`define ETC_BIT_CAPLO       0
`define ETC_RST_T8CTL       8'h00
`define ETC_RST_SHARED      8'h00
`define ETC_RST_PTR         8'h00
`define ETC_LOGIC_AND       2'h0
`define ETC_LOGIC_OR        2'h1
`define ETC_LOGIC_NOR       2'h2
`define ETC_LOGIC_NAND      2'h3
`define ETC_EDGE_FALL       2'h0
`define ETC_EDGE_RISE       2'h1
`define ETC_EDGE_BOTH       2'h2
`endif

// >>> etc_timer_ctl.v
// Eight-bit timer control and shared control with banked register access
`timescale 1ns/100ps
`include "etc_map.vh"
module etc_timer_ctl #(
	parameter W = 8
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [7:0]   reg_addr,
	input  wire [7:0]   reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [7:0]   reg_rdata,
	output wire         ext_sel,
	output wire [3:0]   ext_bank,
	output wire [3:0]   work_group,
	input  wire         count_tick,
	input  wire [W-1:0] init_low,
	input  wire [W-1:0] init_high,
	input  wire         t16_out,
	input  wire         port_out_a,
	input  wire         port_out_b,
	input  wire         edge_input_pin_a,
	input  wire         edge_input_pin_b,
	output wire         timer_out_pin_a,
	output wire         timer_out_pin_b,
	output reg  [W-1:0] capture_low_reg,
	output reg  [W-1:0] capture_high_reg,
	output wire         timeout_irq,
	output wire         capture_irq
);
	reg  [7:0]   ptr_q;
	reg          en_q;
	reg          oneshot_q;
	reg          tc_q;
	reg          capmask_q;
	reg          tomask_q;
	reg          pina_q;
	reg          mode_q;
	reg          pinb_q;
	reg  [1:0]   sel_q;
	reg          caphi_q;
	reg          caplo_q;
	reg  [W-1:0] cnt_q;
	reg          phase_q;
	reg          out_q;
	reg          started_q;
	reg          tick_s1_q;
	reg          tick_s2_q;
	reg          tick_s3_q;
	reg          ina_s1_q;
	reg          ina_s2_q;
	reg          inb_s1_q;
	reg          inb_s2_q;
	reg          in_prev_q;
	wire         tick;
	wire         din;
	wire         rise;
	wire         fall;
	wire         edge_hit;
	wire         hit_t8;
	wire         hit_sh;
	wire         wr_t8;
	wire         wr_sh;
	wire         at_tc;
	wire         timeout;
	reg          comb_out;
	reg  [W-1:0] reload;

	assign ext_bank = ptr_q[3:0];
	assign work_group = ptr_q[7:4];
	assign ext_sel = (ptr_q[3:0] != `ETC_BANK_NORMAL) && (reg_addr[7:4] == 4'h0);
	assign hit_t8 = ext_sel && (ptr_q[3:0] == `ETC_BANK_TIMER)
		&& (reg_addr[3:0] == `ETC_LOC_T8CTL);
	assign hit_sh = ext_sel && (ptr_q[3:0] == `ETC_BANK_TIMER)
		&& (reg_addr[3:0] == `ETC_LOC_SHARED);
	assign wr_t8 = reg_wr && hit_t8;
	assign wr_sh = reg_wr && hit_sh;

	// Tick and pin synchronisers
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
			ina_s1_q <= 1'b0;
			ina_s2_q <= 1'b0;
			inb_s1_q <= 1'b0;
			inb_s2_q <= 1'b0;
			in_prev_q <= 1'b0;
		end
		else
		begin
			tick_s1_q <= count_tick;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
			ina_s1_q <= edge_input_pin_a;
			ina_s2_q <= ina_s1_q;
			inb_s1_q <= edge_input_pin_b;
			inb_s2_q <= inb_s1_q;
			in_prev_q <= din;
		end
	end
	assign tick = tick_s2_q && !tick_s3_q;
	assign din = pinb_q ? inb_s2_q : ina_s2_q;
	assign rise = din && !in_prev_q;
	assign fall = !din && in_prev_q;
	assign edge_hit = (sel_q == `ETC_EDGE_FALL) ? fall :
		(sel_q == `ETC_EDGE_RISE) ? rise :
		(sel_q == `ETC_EDGE_BOTH) ? (rise || fall) : 1'b0;

	assign at_tc = (cnt_q == {{(W-1){1'b0}}, 1'b1});
	assign timeout = en_q && tick && at_tc && (!mode_q || started_q);

	always @*
	begin
		reload = phase_q ? init_high : init_low;
	end

	// Pointer register
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ptr_q <= `ETC_RST_PTR;
		else if (reg_wr && (reg_addr == `ETC_ADDR_BANK_PTR))
			ptr_q <= reg_wdata;
	end

	// Control registers and counter
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_q <= 1'b0;
			oneshot_q <= 1'b0;
			tc_q <= 1'b0;
			capmask_q <= 1'b0;
			tomask_q <= 1'b0;
			pina_q <= 1'b0;
			mode_q <= 1'b0;
			pinb_q <= 1'b0;
			sel_q <= 2'h0;
			caphi_q <= 1'b0;
			caplo_q <= 1'b0;
			cnt_q <= {W{1'b0}};
			phase_q <= 1'b0;
			out_q <= 1'b0;
			started_q <= 1'b0;
			capture_low_reg <= {W{1'b0}};
			capture_high_reg <= {W{1'b0}};
		end
		else
		begin
			if (wr_t8)
			begin
				oneshot_q <= reg_wdata[`ETC_BIT_ONESHOT];
				capmask_q <= reg_wdata[`ETC_BIT_CAPMASK];
				tomask_q <= reg_wdata[`ETC_BIT_TOMASK];
				pina_q <= reg_wdata[`ETC_BIT_PINA];
			end
			if (wr_sh)
			begin
				mode_q <= reg_wdata[`ETC_BIT_MODE];
				pinb_q <= reg_wdata[`ETC_BIT_PINB];
				sel_q <= reg_wdata[5:4];
			end
			if (wr_t8 && reg_wdata[`ETC_BIT_EN] && !en_q)
			begin
				en_q <= 1'b1;
				cnt_q <= init_low;
				phase_q <= 1'b0;
				out_q <= 1'b0;
				started_q <= 1'b0;
			end
			else if (wr_t8 && !reg_wdata[`ETC_BIT_EN])
				en_q <= 1'b0;
			else if (en_q && mode_q)
			begin
				if (edge_hit && !started_q)
					started_q <= 1'b1;
				else if (edge_hit)
				begin
					if (rise)
						capture_high_reg <= ~cnt_q;
					else
						capture_low_reg <= ~cnt_q;
					cnt_q <= reload;
				end
				else if (started_q && tick)
					cnt_q <= at_tc ? reload : cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
			else if (en_q && tick)
			begin
				if (at_tc)
				begin
					out_q <= !out_q;
					phase_q <= !phase_q;
					cnt_q <= phase_q ? init_low : init_high;
					if (oneshot_q)
						en_q <= 1'b0;
				end
				else
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
			if (timeout)
				tc_q <= 1'b1;
			else if (wr_t8 && reg_wdata[`ETC_BIT_TC])
				tc_q <= 1'b0;
			if (en_q && mode_q && started_q && edge_hit && rise)
				caphi_q <= 1'b1;
			else if (wr_sh && reg_wdata[`ETC_BIT_CAPHI])
				caphi_q <= 1'b0;
			if (en_q && mode_q && started_q && edge_hit && !rise)
				caplo_q <= 1'b1;
			else if (wr_sh && reg_wdata[`ETC_BIT_CAPLO])
				caplo_q <= 1'b0;
		end
	end

	always @*
	begin
		case (sel_q)
			`ETC_LOGIC_AND:  comb_out = out_q & t16_out;
			`ETC_LOGIC_OR:   comb_out = out_q | t16_out;
			`ETC_LOGIC_NOR:  comb_out = ~(out_q | t16_out);
			`ETC_LOGIC_NAND: comb_out = ~(out_q & t16_out);
			default:         comb_out = 1'b0;
		endcase
	end
	assign timer_out_pin_a = pina_q ? out_q : port_out_a;
	assign timer_out_pin_b = (!mode_q && pinb_q) ? comb_out : port_out_b;
	assign timeout_irq = tomask_q && tc_q;
	assign capture_irq = capmask_q && (caphi_q || caplo_q);

	// Read back
	always @*
	begin
		reg_rdata = 8'h00;
		if (reg_rd && reg_addr == `ETC_ADDR_BANK_PTR)
			reg_rdata = ptr_q;
		else if (reg_rd && hit_t8)
			reg_rdata = {en_q, oneshot_q, tc_q, 2'b00, capmask_q, tomask_q, pina_q};
		else if (reg_rd && hit_sh)
			reg_rdata = {mode_q, pinb_q, sel_q, 2'b00, caphi_q, caplo_q};
	end
endmodule // etc_timer_ctl

// >>> etc_timer_ctl_sva.sv
// Port-level assertions for the eight-bit timer control block
`timescale 1ns/100ps
module etc_timer_ctl_sva (
	input wire       clk_sys,
	input wire       rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       ext_sel,
	input wire [3:0] ext_bank,
	input wire [3:0] work_group,
	input wire       port_out_a,
	input wire       port_out_b,
	input wire       timer_out_pin_a,
	input wire       timer_out_pin_b,
	input wire       timeout_irq,
	input wire       capture_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire bd = ext_bank == 4'hd;
	wire r0 = reg_rd && bd && reg_addr == 8'h00;
	wire r1 = reg_rd && bd && reg_addr == 8'h01;
	a_ptr_write: assert property (
		reg_wr && reg_addr == 8'hfd |=> {work_group, ext_bank} == $past(reg_wdata))
		else $error("pointer write lost");
	a_normal_bank: assert property (
		ext_bank == 4'h0 |-> !ext_sel) else $error("normal bank swapped");
	a_ext_swap: assert property (
		reg_rd && reg_addr < 8'h10 && ext_bank != 4'h0 |-> ext_sel)
		else $error("bank not swapped");
	a_reserved_loc: assert property (
		reg_rd && bd && reg_addr == 8'h03 |-> reg_rdata == 8'h00)
		else $error("reserved location not zero");
	a_pin_a_port: assert property (
		r0 && !reg_rdata[0] |-> timer_out_pin_a == port_out_a)
		else $error("pin a not port output");
	a_pin_b_port: assert property (
		r1 && reg_rdata[7:6] == 2'b00 |-> timer_out_pin_b == port_out_b)
		else $error("pin b not port output");
	a_timeout_mask: assert property (
		r0 && !reg_rdata[1] |-> !timeout_irq) else $error("timeout request unmasked");
	a_capture_mask: assert property (
		r0 && !reg_rdata[2] |-> !capture_irq) else $error("capture request unmasked");
	a_timeout_held: assert property (
		r0 && reg_rdata[5] && reg_rdata[1] |-> timeout_irq)
		else $error("timeout request not held");
	a_irq_drop: assert property (
		$fell(timeout_irq) |-> $past(reg_wr)) else $error("flag cleared without write");
endmodule // etc_timer_ctl_sva
bind etc_timer_ctl etc_timer_ctl_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ext_sel(ext_sel), .ext_bank(ext_bank), .work_group(work_group),
	.port_out_a(port_out_a), .port_out_b(port_out_b), .timer_out_pin_a(timer_out_pin_a),
	.timer_out_pin_b(timer_out_pin_b), .timeout_irq(timeout_irq), .capture_irq(capture_irq));

// >>> testbench.sv
// Testbench for the eight-bit timer control block
`timescale 1ns/100ps
module testbench;
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic       count_tick = 1'b0;
	logic       t16_out = 1'b0;
	logic       port_out_a = 1'b1;
	logic       port_out_b = 1'b1;
	logic [7:0] init_low = 8'h02;
	logic [7:0] init_high = 8'h02;
	logic       pin_a = 1'b0;
	logic       pin_b = 1'b0;
	wire  [7:0] reg_addr, reg_wdata, reg_rdata, cap_lo, cap_hi;
	wire  [3:0] ext_bank, work_group;
	wire        reg_wr, reg_rd, ext_sel, out_a, out_b, to_irq, cap_irq;
	logic [7:0] rv;
	logic [3:0] f;
	int         i, mismatches = 0, num_checks = 0;
	etc_core_model core (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	etc_timer_ctl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_sel(ext_sel), .ext_bank(ext_bank), .work_group(work_group),
		.count_tick(count_tick), .init_low(init_low), .init_high(init_high),
		.t16_out(t16_out), .port_out_a(port_out_a), .port_out_b(port_out_b),
		.edge_input_pin_a(pin_a), .edge_input_pin_b(pin_b), .timer_out_pin_a(out_a),
		.timer_out_pin_b(out_b), .capture_low_reg(cap_lo), .capture_high_reg(cap_hi),
		.timeout_irq(to_irq), .capture_irq(cap_irq));
	always #20 clk_sys = ~clk_sys;
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
	begin
		num_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task t_reset;
	begin
		core.rd(8'hfd, rv);
		chk("ptr", rv, 8'h00);
		core.wr(8'hfd, 8'h5d);
		chk("group_bank", {work_group, ext_bank}, 8'h5d);
		core.rd(8'h00, rv);
		chk("t8ctl", rv, 8'h00);
		core.rd(8'h01, rv);
		chk("shared", rv, 8'h00);
		core.rd(8'h03, rv);
		chk("reserved", rv, 8'h00);
		chk("pin_a", {7'h0, out_a}, {7'h0, port_out_a});
		chk("pin_b", {7'h0, out_b}, {7'h0, port_out_b});
	end
	endtask
	task t_oneshot;
	begin
		core.wr(8'h00, 8'h20);
		core.wr(8'h00, 8'hc2);
		repeat (12)
		begin
			count_tick <= 1'b1;
			repeat (4) @(posedge clk_sys);
			count_tick <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		chk("to_irq", {7'h0, to_irq}, 8'h01);
		core.rd(8'h00, rv);
		chk("tc_flag", {7'h0, rv[5]}, 8'h01);
		core.wr(8'h00, 8'h22);
		chk("irq_drop", {7'h0, to_irq}, 8'h00);
		core.rd(8'h00, rv);
		chk("tc_clear", rv, 8'h02);
	end
	endtask
	task t_combine;
	begin
		core.wr(8'h00, 8'h01);
		for (i = 0; i < 8; i++)
		begin
			t16_out <= i[0];
			core.wr(8'h01, {2'b01, i[2:1], 4'h0});
			@(negedge clk_sys);
			f = {~(out_a & t16_out), ~(out_a | t16_out), out_a | t16_out, out_a & t16_out};
			chk("combine", {7'h0, out_b}, {7'h0, f[i[2:1]]});
			@(posedge clk_sys);
		end
	end
	endtask
	task t_demod;
	begin
		init_low <= 8'hff;
		init_high <= 8'hff;
		core.wr(8'h01, 8'h90);
		core.wr(8'h00, 8'h84);
		pin_a <= 1'b1;
		repeat (6) @(posedge clk_sys);
		repeat (3)
		begin
			count_tick <= 1'b1;
			repeat (4) @(posedge clk_sys);
			count_tick <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		pin_a <= 1'b0;
		repeat (4) @(posedge clk_sys);
		pin_a <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("cap_hi", cap_hi, 8'h03);
		chk("cap_irq", {7'h0, cap_irq}, 8'h01);
		core.rd(8'h01, rv);
		chk("shared_demod", rv, 8'h92);
		core.wr(8'h01, 8'h92);
		chk("cap_irq_drop", {7'h0, cap_irq}, 8'h00);
		core.wr(8'h00, 8'h00);
		core.wr(8'h01, 8'h00);
	end
	endtask
	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish;
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_oneshot;
		t_combine;
		t_demod;
		tally_and_finish;
	end
endmodule // testbench
